// ===== core/rtc_osc_pkg.sv
package rtc_osc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  localparam int unsigned SELF_MIN_HZ = 10_000;
  localparam int unsigned SELF_MAX_HZ = 40_000;
  localparam int unsigned SELF_LOW_HZ = 20_000;
  localparam int unsigned SELF_HIGH_HZ = 40_000;
  // Half periods of the self-oscillation tick, rounded down
  localparam int unsigned HALF_LOW_CYC = CLK_HZ / (2 * SELF_LOW_HZ);
  localparam int unsigned HALF_HIGH_CYC = CLK_HZ / (2 * SELF_HIGH_HZ);
  localparam int unsigned HALF_MAX_CYC = CLK_HZ / (2 * SELF_MIN_HZ);
  localparam int unsigned HALF_MIN_CYC = CLK_HZ / (2 * SELF_MAX_HZ);
  // Extra half-period cycles per load capacitance step
  localparam int unsigned CAP_TRIM_CYC = 20;
  localparam int unsigned BLANK_MS = 2;
  localparam int unsigned BLANK_CYC = (CLK_HZ / 1000) * BLANK_MS;
  localparam int unsigned STEP_US = 500;
  localparam int unsigned STEP_CYC = (CLK_HZ / 1_000_000) * STEP_US;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned HALF_W = 12;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] OSC_CONTROL_REG = 4'h0;
  localparam logic [3:0] LOAD_CAP_CONFIG = 4'h1;
  localparam logic [3:0] IRQ_STATUS_REG = 4'h2;
  localparam logic [3:0] IRQ_CLEAR_REG = 4'h3;
  localparam logic [3:0] IRQ_ENABLE_REG = 4'h4;
  localparam logic [3:0] CAP_APPLIED_REG = 4'h5;

  // osc_control_reg fields
  localparam int unsigned MODE_BIT = 7;
  localparam int unsigned GAIN_BIT = 6;
  localparam int unsigned BIAS_BIT = 5;
  localparam int unsigned VALID_BIT = 4;
  localparam int unsigned FAIL_BIT = 3;
  localparam int unsigned POWER_BIT = 0;
  localparam logic [7:0] OSC_CONTROL_RESET = 8'h00;

  // load_cap_config fields
  localparam int unsigned AUTO_STEP_BIT = 7;
  localparam int unsigned READY_BIT = 6;
  localparam int unsigned CAP_LSB = 0;
  localparam int unsigned CAP_W = 4;
  localparam logic [3:0] CAP_SMALLEST = 4'h0;
  localparam logic [3:0] CAP_RESET = 4'h0;

  // Event bits of status, clear and enable registers
  localparam int unsigned EV_READY = 0;
  localparam int unsigned EV_VALID = 1;
  localparam int unsigned EV_FAIL = 2;
  localparam int unsigned EV_W = 3;

  typedef enum logic [1:0] {
    STEP_IDLE = 2'b00,
    STEP_RAMP = 2'b01,
    STEP_DONE = 2'b10
  } step_state_type;

endpackage : rtc_osc_pkg

// ===== core/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Three-stage input synchroniser with agreement filter
// ============================================================================
module pin_sync3 (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      level_out <= stage3_r;
    end
  end

endmodule : pin_sync3

`default_nettype wire

// ===== core/rtc_oscillator_control.sv
// Notes on behaviour
// R1 - The oscillator domain ticks from its own timebase, 32.768 kHz crystal or a 10 to 40 kHz self-oscillation.
// R2 - osc_mode_select at 1 picks crystal operation and at 0 self-oscillation.
// R3 - Software starts the crystal by mode, gain off and bias doubled, load cap, power, then waits 20 ms.
// R4 - Software then polls valid and ready, sets gain, clears bias, enables fail detection, waits 2 ms, clears wake flags.
// R5 - Self-oscillation runs near 20 kHz with bias_double 0 and near 40 kHz with bias_double 1.
// R6 - Self-oscillation starts at once after configuration, with no settling wait.
// R7 - load_cap_value is 4 bits, code 0 the smallest capacitance and each higher code a larger one.
// R8 - With automatic stepping the applied capacitance starts at the smallest code and climbs to the programmed one.
// R9 - load_cap_ready goes to 1 once the applied capacitance equals the programmed value; after reset it stays 0 until load_cap_config is written.
// R10 - Software keeps gain_control_enable cleared in self-oscillation.
// R11 - bias_double sits at bit 5 of osc_control_reg and is enabled by writing 1.
// R12 - With a CMOS clock software uses lowest bias, gain off, ignores valid and checks the fail flag after 2 ms.
// R13 - Writing a new load_cap_value clears load_cap_ready until stepping reaches it.
`timescale 1ns/1ps
`default_nettype none

module rtc_oscillator_control #(
  parameter int unsigned BLANK_CYCLES = rtc_osc_pkg::BLANK_CYC,
  parameter int unsigned STEP_CYCLES = rtc_osc_pkg::STEP_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic osc_clk_pin_in,
  input wire logic crystal_amp_ok_in,
  input wire logic osc_fail_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out,
  output logic osc_mode_select_out,
  output logic gain_control_enable_out,
  output logic bias_double_out,
  output logic osc_power_enable_out,
  output logic [3:0] load_cap_applied_out,
  output logic rtc_tick_out
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [rtc_osc_pkg::CNT_W-1:0] BLANK_LIMIT =
    rtc_osc_pkg::CNT_W'(BLANK_CYCLES);
  localparam logic [rtc_osc_pkg::CNT_W-1:0] STEP_LIMIT =
    rtc_osc_pkg::CNT_W'(STEP_CYCLES);
  localparam logic [rtc_osc_pkg::HALF_W-1:0] HALF_LOW =
    rtc_osc_pkg::HALF_W'(rtc_osc_pkg::HALF_LOW_CYC);
  localparam logic [rtc_osc_pkg::HALF_W-1:0] HALF_HIGH =
    rtc_osc_pkg::HALF_W'(rtc_osc_pkg::HALF_HIGH_CYC);
  localparam logic [rtc_osc_pkg::HALF_W-1:0] HALF_MAX =
    rtc_osc_pkg::HALF_W'(rtc_osc_pkg::HALF_MAX_CYC);
  localparam logic [rtc_osc_pkg::HALF_W-1:0] HALF_MIN =
    rtc_osc_pkg::HALF_W'(rtc_osc_pkg::HALF_MIN_CYC);
  localparam logic [7:0] CAP_TRIM =
    8'(rtc_osc_pkg::CAP_TRIM_CYC);

  logic mode_r;
  logic gain_r;
  logic bias_r;
  logic power_r;
  logic auto_step_r;
  logic [3:0] cap_value_r;
  logic [3:0] cap_applied_r;
  logic cap_ready_r;
  rtc_osc_pkg::step_state_type step_state_r;
  logic [rtc_osc_pkg::CNT_W-1:0] step_cnt_r;
  logic [rtc_osc_pkg::CNT_W-1:0] blank_cnt_r;
  logic blank_done_r;
  logic valid_r;
  logic fail_r;
  logic [rtc_osc_pkg::EV_W-1:0] status_r;
  logic [rtc_osc_pkg::EV_W-1:0] irq_enable_r;
  logic [rtc_osc_pkg::EV_W-1:0] status_nxt;
  logic [rtc_osc_pkg::EV_W-1:0] event_set;
  logic [rtc_osc_pkg::EV_W-1:0] event_clear;
  logic ready_prev_r;
  logic valid_prev_r;
  logic fail_prev_r;
  logic [rtc_osc_pkg::HALF_W-1:0] half_cnt_r;
  logic [rtc_osc_pkg::HALF_W-1:0] half_target;
  logic self_clk_r;
  logic pin_prev_r;
  logic osc_pin_sync;
  logic amp_ok_sync;
  logic fail_sync;
  logic wr_ctrl;
  logic wr_cap;
  logic [7:0] ctrl_view;
  logic [7:0] cap_view;
  logic [7:0] rdata_nxt;

  assign wr_ctrl = reg_write_in && (reg_addr_in == rtc_osc_pkg::OSC_CONTROL_REG);
  assign wr_cap = reg_write_in && (reg_addr_in == rtc_osc_pkg::LOAD_CAP_CONFIG);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  pin_sync3 u_sync_osc (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(osc_clk_pin_in),
    .level_out(osc_pin_sync)
  );

  pin_sync3 u_sync_amp (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(crystal_amp_ok_in),
    .level_out(amp_ok_sync)
  );

  pin_sync3 u_sync_fail (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(osc_fail_in),
    .level_out(fail_sync)
  );

  // ==========================================================================
  // Oscillator control register
  // ==========================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= 1'b0;
      gain_r <= 1'b0;
      bias_r <= 1'b0;
      power_r <= 1'b0;
    end else if (wr_ctrl) begin
      mode_r <= reg_wdata_in[rtc_osc_pkg::MODE_BIT]; // R2
      gain_r <= reg_wdata_in[rtc_osc_pkg::GAIN_BIT];
      bias_r <= reg_wdata_in[rtc_osc_pkg::BIAS_BIT]; // R11
      power_r <= reg_wdata_in[rtc_osc_pkg::POWER_BIT];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      osc_mode_select_out <= 1'b0;
      gain_control_enable_out <= 1'b0;
      bias_double_out <= 1'b0;
      osc_power_enable_out <= 1'b0;
      load_cap_applied_out <= rtc_osc_pkg::CAP_RESET;
    end else begin
      osc_mode_select_out <= mode_r; // R2
      gain_control_enable_out <= gain_r;
      bias_double_out <= bias_r; // R11
      osc_power_enable_out <= power_r;
      load_cap_applied_out <= cap_applied_r; // R7
    end
  end

  // ==========================================================================
  // Load capacitance configuration and stepping
  // ==========================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      auto_step_r <= 1'b0;
      cap_value_r <= rtc_osc_pkg::CAP_RESET;
    end else if (wr_cap) begin
      auto_step_r <= reg_wdata_in[rtc_osc_pkg::AUTO_STEP_BIT];
      cap_value_r <= reg_wdata_in[rtc_osc_pkg::CAP_LSB +:
                                  rtc_osc_pkg::CAP_W]; // R7
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      step_state_r <= rtc_osc_pkg::STEP_IDLE;
      cap_applied_r <= rtc_osc_pkg::CAP_RESET;
      cap_ready_r <= 1'b0;
      step_cnt_r <= '0;
    end else if (wr_cap) begin
      cap_ready_r <= 1'b0; // R13
      step_cnt_r <= '0;
      step_state_r <= rtc_osc_pkg::STEP_RAMP;
      if (reg_wdata_in[rtc_osc_pkg::AUTO_STEP_BIT]) begin
        cap_applied_r <= rtc_osc_pkg::CAP_SMALLEST; // R8
      end else begin
        cap_applied_r <= reg_wdata_in[rtc_osc_pkg::CAP_LSB +:
                                      rtc_osc_pkg::CAP_W];
      end
    end else begin
      unique case (step_state_r)
        rtc_osc_pkg::STEP_IDLE: begin
          cap_ready_r <= 1'b0;
        end
        rtc_osc_pkg::STEP_RAMP: begin
          if (cap_applied_r == cap_value_r) begin
            cap_ready_r <= 1'b1; // R9
            step_state_r <= rtc_osc_pkg::STEP_DONE;
          end else if (step_cnt_r >= STEP_LIMIT - 1'b1) begin
            step_cnt_r <= '0;
            cap_applied_r <= cap_applied_r + 4'h1; // R8
          end else begin
            step_cnt_r <= step_cnt_r + 1'b1;
          end
        end
        rtc_osc_pkg::STEP_DONE: begin
          cap_ready_r <= 1'b1; // R9
        end
        default: begin
          step_state_r <= rtc_osc_pkg::STEP_IDLE;
          cap_ready_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Crystal valid detection with blanking after power on
  // ==========================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      blank_cnt_r <= '0;
      blank_done_r <= 1'b0;
    end else if (!power_r || !mode_r) begin
      blank_cnt_r <= '0;
      blank_done_r <= 1'b0;
    end else if (!blank_done_r) begin
      if (blank_cnt_r >= BLANK_LIMIT - 1'b1) begin
        blank_done_r <= 1'b1;
      end else begin
        blank_cnt_r <= blank_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      valid_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      valid_r <= blank_done_r && amp_ok_sync;
      fail_r <= power_r && fail_sync;
    end
  end

  // ==========================================================================
  // Oscillator timebase
  // ==========================================================================
  // Higher load capacitance lowers the self-oscillation frequency
  always_comb begin
    half_target = bias_r ? HALF_HIGH : HALF_LOW; // R5
    half_target = half_target +
      rtc_osc_pkg::HALF_W'(cap_applied_r) * rtc_osc_pkg::HALF_W'(CAP_TRIM);
    if (half_target > HALF_MAX) begin
      half_target = HALF_MAX; // R1
    end
    if (half_target < HALF_MIN) begin
      half_target = HALF_MIN; // R1
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt_r <= '0;
      self_clk_r <= 1'b0;
    end else if (!power_r || mode_r) begin
      half_cnt_r <= '0;
      self_clk_r <= 1'b0;
    end else if (half_cnt_r >= half_target - 1'b1) begin
      half_cnt_r <= '0;
      self_clk_r <= !self_clk_r; // R6
    end else begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_r <= 1'b0;
      rtc_tick_out <= 1'b0;
    end else begin
      pin_prev_r <= osc_pin_sync;
      if (!power_r) begin
        rtc_tick_out <= 1'b0;
      end else if (mode_r) begin
        rtc_tick_out <= osc_pin_sync && !pin_prev_r; // R1
      end else begin
        rtc_tick_out <= !self_clk_r && (half_cnt_r >= half_target - 1'b1);
      end
    end
  end

  // ==========================================================================
  // Interrupt status, clear and enable
  // ==========================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ready_prev_r <= 1'b0;
      valid_prev_r <= 1'b0;
      fail_prev_r <= 1'b0;
    end else begin
      ready_prev_r <= cap_ready_r;
      valid_prev_r <= valid_r;
      fail_prev_r <= fail_r;
    end
  end

  always_comb begin
    event_set = '0;
    event_set[rtc_osc_pkg::EV_READY] = cap_ready_r && !ready_prev_r;
    event_set[rtc_osc_pkg::EV_VALID] = valid_r && !valid_prev_r;
    event_set[rtc_osc_pkg::EV_FAIL] = fail_r && !fail_prev_r;
    event_clear = '0;
    if (reg_write_in && (reg_addr_in == rtc_osc_pkg::IRQ_CLEAR_REG)) begin
      event_clear = reg_wdata_in[rtc_osc_pkg::EV_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    status_nxt = (status_r & ~event_clear) | event_set;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= '0;
      irq_enable_r <= '0;
      irq_out <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (reg_write_in && (reg_addr_in == rtc_osc_pkg::IRQ_ENABLE_REG)) begin
        irq_enable_r <= reg_wdata_in[rtc_osc_pkg::EV_W-1:0];
      end
      irq_out <= |(status_r & irq_enable_r);
    end
  end

  // ==========================================================================
  // Register read path
  // ==========================================================================
  always_comb begin
    ctrl_view = rtc_osc_pkg::OSC_CONTROL_RESET;
    ctrl_view[rtc_osc_pkg::MODE_BIT] = mode_r;
    ctrl_view[rtc_osc_pkg::GAIN_BIT] = gain_r;
    ctrl_view[rtc_osc_pkg::BIAS_BIT] = bias_r;
    ctrl_view[rtc_osc_pkg::VALID_BIT] = valid_r;
    ctrl_view[rtc_osc_pkg::FAIL_BIT] = fail_r;
    ctrl_view[rtc_osc_pkg::POWER_BIT] = power_r;
    cap_view = '0;
    cap_view[rtc_osc_pkg::AUTO_STEP_BIT] = auto_step_r;
    cap_view[rtc_osc_pkg::READY_BIT] = cap_ready_r; // R9
    cap_view[rtc_osc_pkg::CAP_LSB +: rtc_osc_pkg::CAP_W] = cap_value_r;
    unique case (reg_addr_in)
      rtc_osc_pkg::OSC_CONTROL_REG: rdata_nxt = ctrl_view;
      rtc_osc_pkg::LOAD_CAP_CONFIG: rdata_nxt = cap_view;
      rtc_osc_pkg::IRQ_STATUS_REG: rdata_nxt = 8'(status_r);
      rtc_osc_pkg::IRQ_ENABLE_REG: rdata_nxt = 8'(irq_enable_r);
      rtc_osc_pkg::CAP_APPLIED_REG: rdata_nxt = 8'(cap_applied_r);
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= rdata_nxt;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule : rtc_oscillator_control

`default_nettype wire

// ===== sim/rtc_osc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_properties #(
  parameter int unsigned BLANK_CYCLES = 20,
  parameter int unsigned STEP_CYCLES = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic osc_clk_pin_in,
  input wire logic crystal_amp_ok_in,
  input wire logic osc_fail_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic irq_out,
  input wire logic osc_mode_select_out,
  input wire logic gain_control_enable_out,
  input wire logic bias_double_out,
  input wire logic osc_power_enable_out,
  input wire logic [3:0] load_cap_applied_out,
  input wire logic rtc_tick_out
);
  logic [12:0] gap_r;
  logic [2:0] cap_wr_r;
  logic [6:0] cfg_r;
  logic ok_r;
  logic [6:0] cfg;
  logic [12:0] per;
  assign cfg = {osc_mode_select_out, osc_power_enable_out, bias_double_out,
    load_cap_applied_out};
  // Expected self-oscillation period: two half periods
  assign per = ((bias_double_out ? 13'h0271 : 13'h04E2)
    + 13'(load_cap_applied_out) * 13'h0014) << 1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= 13'h0000;
      cap_wr_r <= 3'h0;
      cfg_r <= 7'h00;
      ok_r <= 1'b0;
    end else begin
      gap_r <= (rtc_tick_out || !cfg[5] || cfg[6]) ? 13'h0000 : gap_r + 13'h0001;
      cap_wr_r <= {cap_wr_r[1:0], reg_write_in && reg_addr_in == 4'h1};
      cfg_r <= cfg;
      ok_r <= (cfg_r != cfg) ? 1'b0 : (rtc_tick_out ? 1'b1 : ok_r);
    end
  end
  rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  mode_follow_a: assert property (
    reg_write_in && reg_addr_in == 4'h0 |-> ##2
    osc_mode_select_out == $past(reg_wdata_in[7], 2))
    else $error("mode select does not follow control write");
  bias_follow_a: assert property (
    reg_write_in && reg_addr_in == 4'h0 |-> ##2
    bias_double_out == $past(reg_wdata_in[5], 2))
    else $error("bias double does not follow control bit five");
  ramp_start_a: assert property (
    reg_write_in && reg_addr_in == 4'h1 && reg_wdata_in[7] |-> ##[1:2]
    load_cap_applied_out == 4'h0)
    else $error("stepping did not start at smallest capacitance");
  ramp_step_a: assert property (
    load_cap_applied_out != $past(load_cap_applied_out) && cap_wr_r == 3'h0
    |-> load_cap_applied_out == $past(load_cap_applied_out) + 4'h1)
    else $error("applied capacitance jumped by more than one step");
  tick_off_a: assert property (
    !osc_power_enable_out && !$past(osc_power_enable_out) |-> !rtc_tick_out)
    else $error("tick while oscillator powered off");
  self_period_a: assert property (
    rtc_tick_out && ok_r && !osc_mode_select_out && gap_r != 13'h0000
    |-> gap_r + 13'h0003 >= per && gap_r <= per + 13'h0001)
    else $error("self oscillation period off");
  self_start_a: assert property (
    osc_power_enable_out && !osc_mode_select_out |-> gap_r < 13'h1392)
    else $error("self oscillation not ticking");
  cover property (rtc_tick_out && !osc_mode_select_out);
  cover property (rtc_tick_out && osc_mode_select_out);
  cover property ($rose(irq_out));
  cover property (load_cap_applied_out == 4'hF);
endmodule : rtc_osc_properties
bind rtc_oscillator_control rtc_osc_properties #(
  .BLANK_CYCLES(BLANK_CYCLES), .STEP_CYCLES(STEP_CYCLES)) props (
  .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .osc_clk_pin_in(osc_clk_pin_in),
  .crystal_amp_ok_in(crystal_amp_ok_in), .osc_fail_in(osc_fail_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
  .osc_mode_select_out(osc_mode_select_out),
  .gain_control_enable_out(gain_control_enable_out),
  .bias_double_out(bias_double_out),
  .osc_power_enable_out(osc_power_enable_out),
  .load_cap_applied_out(load_cap_applied_out), .rtc_tick_out(rtc_tick_out));
`default_nettype wire

// ===== sim/xtal_source.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Crystal model: runs only while powered, amplitude good after a delay
// ============================================================================
module xtal_source #(
  parameter real HALF_NS = 15258.789,
  parameter int AMP_NS = 2000
) (
  input wire logic power_in,
  input wire logic stop_in,
  output var logic pin_out,
  output var logic amp_ok_out,
  output wire logic fail_out
);
  initial pin_out = 1'b0;
  initial amp_ok_out = 1'b0;
  always begin
    #HALF_NS;
    pin_out = power_in && !stop_in && !pin_out;
  end
  always @(posedge power_in) begin
    #AMP_NS;
    amp_ok_out = power_in;
  end
  always @(negedge power_in) amp_ok_out = 1'b0;
  // Stopped clock is seen by the missing-clock detector
  assign fail_out = power_in && stop_in;
endmodule : xtal_source
`default_nettype wire

// ===== sim/tb_rtc_oscillator_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_oscillator_control;
  localparam int HH = rtc_osc_pkg::HALF_HIGH_CYC;
  localparam int HL = rtc_osc_pkg::HALF_LOW_CYC;
  localparam int TRIM = rtc_osc_pkg::CAP_TRIM_CYC;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [7:0] d;
  } row_type;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop = 1'b0;
  logic pin, amp, fail, irq, mode, gain, bias, pwr, tick;
  logic [7:0] rdata, d;
  logic [3:0] applied;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int w, n;
  row_type rows [16] = '{
    '{1'b0, 4'h0, 8'h00}, '{1'b0, 4'h1, 8'h00}, '{1'b0, 4'h2, 8'h00},
    '{1'b0, 4'h4, 8'h00}, '{1'b0, 4'h5, 8'h00}, '{1'b1, 4'h6, 8'hFF},
    '{1'b0, 4'h6, 8'h00}, '{1'b1, 4'h0, 8'h78}, '{1'b0, 4'h0, 8'h60},
    '{1'b1, 4'h0, 8'h00}, '{1'b1, 4'h4, 8'h07}, '{1'b0, 4'h4, 8'h07},
    '{1'b1, 4'h4, 8'h00}, '{1'b1, 4'h1, 8'h03}, '{1'b0, 4'h5, 8'h03},
    '{1'b0, 4'h1, 8'h43}};
  always #10 clock_in = ~clock_in;
  rtc_oscillator_control #(.BLANK_CYCLES(20), .STEP_CYCLES(4)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .osc_clk_pin_in(pin), .crystal_amp_ok_in(amp), .osc_fail_in(fail),
    .reg_rdata_out(rdata), .irq_out(irq), .osc_mode_select_out(mode),
    .gain_control_enable_out(gain), .bias_double_out(bias),
    .osc_power_enable_out(pwr), .load_cap_applied_out(applied),
    .rtc_tick_out(tick));
  xtal_source partner (.power_in(pwr), .stop_in(stop), .pin_out(pin),
    .amp_ok_out(amp), .fail_out(fail));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic chk_near(input string s, input int e, input int g);
    n_compared++;
    if (g < e - 2 || g > e + 2) begin
      $display("unexpected %s expected %0d seen %0d", s, e, g);
      miscompares++;
    end
  endtask : chk_near
  task automatic wr8(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    @(negedge clock_in);
    v = rdata;
  endtask : rd8
  task automatic poll(input logic [3:0] a, input int b);
    int i;
    i = 0;
    d = 8'h00;
    while (d[b] !== 1'b1 && i < 300) begin
      rd8(a, d);
      i++;
    end
    chk("polled flag", 8'h01, {7'h00, d[b]});
  endtask : poll
  // Time to first tick in w, then one full period in n
  task automatic meas();
    w = 0;
    while (tick !== 1'b1 && w < 6000) begin
      @(negedge clock_in);
      w++;
    end
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (tick !== 1'b1 && n < 6000);
  endtask : meas
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    // ==========================================================================
    // Register table rows
    // ==========================================================================
    foreach (rows[i]) begin
      if (rows[i].wr)
        wr8(rows[i].a, rows[i].d);
      else begin
        rd8(rows[i].a, d);
        chk("register row", rows[i].d, d);
      end
    end
    // ==========================================================================
    // Self oscillation
    // ==========================================================================
    wr8(4'h1, 8'h00);
    wr8(4'h0, 8'h21);
    meas();
    chk_near("start delay", 0, (w <= 2 * HH + 10) ? 0 : w);
    meas();
    chk_near("fast period", 2 * HH, n);
    wr8(4'h0, 8'h01);
    meas();
    meas();
    chk_near("slow period", 2 * HL, n);
    wr8(4'h1, 8'h03);
    meas();
    meas();
    chk_near("trimmed period", 2 * (HL + 3 * TRIM), n);
    wr8(4'h0, 8'h00);
    repeat (5) @(negedge clock_in);
    n = 0;
    repeat (3000) begin
      @(negedge clock_in);
      n += int'(tick === 1'b1);
    end
    chk_near("ticks while off", 0, n);
    // ==========================================================================
    // Automatic stepping and interrupt
    // ==========================================================================
    wr8(4'h3, 8'h07);
    wr8(4'h4, 8'h01);
    wr8(4'h1, 8'h85);
    rd8(4'h1, d);
    chk("ready after write", 8'h85, d);
    chk("applied at start", 8'h00, {4'h0, applied});
    poll(4'h1, 6);
    chk("applied final", 8'h05, {4'h0, applied});
    repeat (2) @(negedge clock_in);
    chk("irq raised", 8'h01, {7'h00, irq});
    rd8(4'h2, d);
    chk("status ready", 8'h01, d);
    wr8(4'h4, 8'h00);
    repeat (2) @(negedge clock_in);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr8(4'h3, 8'h01);
    rd8(4'h2, d);
    chk("status cleared", 8'h00, d);
    wr8(4'h1, 8'h8F);
    rd8(4'h1, d);
    chk("ready after rewrite", 8'h8F, d);
    poll(4'h1, 6);
    chk("applied top code", 8'h0F, {4'h0, applied});
    // ==========================================================================
    // Crystal start-up sequence
    // ==========================================================================
    wr8(4'h0, 8'h80);
    wr8(4'h0, 8'hA0);
    wr8(4'h1, 8'h87);
    wr8(4'h0, 8'hA1);
    repeat (40) @(posedge clock_in);
    poll(4'h0, 4);
    poll(4'h1, 6);
    wr8(4'h0, 8'hC1);
    wr8(4'h3, 8'h07);
    chk("gain enable", 8'h01, {7'h00, gain});
    meas();
    meas();
    chk_near("crystal period", 1526, n);
    stop <= 1'b1;
    repeat (10) @(posedge clock_in);
    rd8(4'h0, d);
    chk("fail flag", 8'h01, {7'h00, d[3]});
    rd8(4'h2, d);
    chk("fail status", 8'h01, {7'h00, d[2]});
    rst_in <= 1'b1;
    @(posedge clock_in);
    rst_in <= 1'b0;
    rd8(4'h0, d);
    chk("ctrl after reset", 8'h00, d);
    chk("applied after reset", 8'h00, {4'h0, applied});
    complete_run();
  end
endmodule : tb_rtc_oscillator_control
`default_nettype wire
